/* File: core/slu_pkg.sv */
/*
 * slu_pkg: constants shared by the stack linkage unit.
 * Assumes 16-bit byte addresses, word-aligned stacks and a word-wide storage port.
 */
package slu_pkg;
   // =========================================================
   // widths and sizes
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned NUM_REGS   = 8;
   localparam int unsigned REG_IDX_W  = 3;
   localparam int unsigned WORK_W     = 8;
   localparam logic [15:0] WORD_BYTES = 16'h0002;
   localparam logic [2:0]  LINK_REG   = 3'h7;
   // =========================================================
   // control word field positions
   localparam int unsigned CTL_N_LSB  = 0;
   localparam int unsigned CTL_RL_LSB = 8;
   // =========================================================
   // control block word offsets
   localparam logic [15:0] SCB_HIGH_OFS = 16'h0000;
   localparam logic [15:0] SCB_LOW_OFS  = 16'h0002;
   localparam logic [15:0] SCB_TOP_OFS  = 16'h0004;
   // =========================================================
   // reset values
   localparam logic [15:0] WORD_RST = 16'h0000;
   // =========================================================
   // operation codes
   typedef enum logic [1:0]
   {
      SLU_OP_POP_WORD,
      SLU_OP_PUSH_WORD,
      SLU_OP_STORE_BLOCK_PUSH,
      SLU_OP_LOAD_BLOCK_RETURN
   } slu_op_e;
endpackage : slu_pkg

/* File: core/slu_core.sv */
/*
 * slu_core: word pop/push and the block linkage pair (store-block-push,
 * load-block-return) on a main-storage stack with a three-word control block.
 * Assumes one storage requester; storage answers each held request with a
 * one-cycle ack (read data valid with it). Commands only start while idle.
 */
`timescale 1ns/1ps
`default_nettype none
module slu_core
#(
   parameter int unsigned WORK_W = slu_pkg::WORK_W
)
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                reset,
   // command
   input  wire logic                cmd_start,
   input  wire logic [1:0]          cmd_op,
   input  wire logic [2:0]          cmd_reg,
   input  wire logic [WORK_W-1:0]   cmd_work,
   input  wire logic [15:0]         cmd_scb_addr,
   // general register access
   input  wire logic                reg_wr_en,
   input  wire logic [2:0]          reg_wr_idx,
   input  wire logic [15:0]         reg_wr_data,
   input  wire logic [2:0]          reg_rd_idx,
   output logic      [15:0]         reg_rd_data_r,
   // status
   output logic                     busy_r,
   output logic                     done_r,
   output logic                     stack_trap_r,
   output logic                     stack_empty_r,
   output logic      [15:0]         instruction_pointer_r,
   // main storage
   output logic                     mem_req_r,
   output logic                     mem_we_r,
   output logic      [15:0]         mem_addr_r,
   output logic      [15:0]         mem_wdata_r,
   input  wire logic [15:0]         mem_rdata,
   input  wire logic                mem_ack
);
   // =========================================================
   // helpers
   // saved register count for a limit register
   function automatic logic [3:0] reg_count(input logic [2:0] rl);
      reg_count = (rl == slu_pkg::LINK_REG) ? 4'h1 : 4'({1'b0, rl} + 4'h2);
   endfunction : reg_count

   // block size in bytes
   function automatic logic [15:0] block_bytes(input logic [2:0] rl,
                                               input logic [WORK_W-1:0] n);
      block_bytes = 16'((16'(n) + 16'(reg_count(rl)) + 16'h0001) << 1);
   endfunction : block_bytes

   typedef enum {
      S_IDLE, S_RD_HIGH, S_RD_LOW, S_RD_TOP, S_CHECK, S_RD_CTL,
      S_CHECK_RET, S_XFER, S_WR_CTL, S_SET_RL, S_WR_TOP, S_FINISH
   } slu_state_e;

   slu_state_e        state_r;
   slu_pkg::slu_op_e  op_r;
   logic [2:0]        reg_r;
   logic [WORK_W-1:0] work_r;
   logic [15:0]       scb_r;
   logic [15:0]       high_r;
   logic [15:0]       low_r;
   logic [15:0]       top_r;
   logic [15:0]       new_top_r;
   logic [3:0]        slot_r;
   logic [15:0]       gpr_r [slu_pkg::NUM_REGS];

   // =========================================================
   // decode of the current step
   wire        is_stm      = (op_r == slu_pkg::SLU_OP_STORE_BLOCK_PUSH);
   wire        is_lmb      = (op_r == slu_pkg::SLU_OP_LOAD_BLOCK_RETURN);
   wire        is_push     = (op_r == slu_pkg::SLU_OP_PUSH_WORD);
   wire        is_store    = is_stm | is_push;
   wire [15:0] blk_bytes   = block_bytes(reg_r, work_r);
   wire [15:0] work_bytes  = 16'(16'(work_r) << 1);
   wire [15:0] push_top    = 16'(top_r - (is_stm ? blk_bytes : slu_pkg::WORD_BYTES));
   wire [15:0] ret_top     = 16'(top_r + blk_bytes);
   // block base: new top on push, current top (control word) on return
   wire [15:0] frame_base  = is_lmb ? top_r : new_top_r;
   wire [15:0] work_ptr    = 16'(frame_base + slu_pkg::WORD_BYTES);
   wire [15:0] link_slot   = 16'(work_ptr + work_bytes);
   // pop reads the element at the current top, push writes the lowered top
   wire [15:0] base_addr   = (is_stm | is_lmb) ? link_slot :
                             (is_push ? new_top_r : top_r);
   wire [15:0] slot_addr   = 16'(base_addr + 16'({slot_r, 1'b0}));
   wire [3:0]  slot_total  = (is_stm | is_lmb) ? reg_count(reg_r) : 4'h1;
   wire        slot_last   = (slot_r == 4'(slot_total - 4'h1));
   wire [2:0]  slot_reg    = !(is_stm | is_lmb) ? reg_r :
                             (slot_r == 4'h0) ? slu_pkg::LINK_REG : 3'(slot_r - 4'h1);
   wire [15:0] ctl_word    = 16'((16'(reg_r) << slu_pkg::CTL_RL_LSB) |
                                 (16'(work_r) << slu_pkg::CTL_N_LSB));
   wire        overflow    = (push_top < low_r) | (push_top > top_r);
   wire        underflow   = (top_r >= high_r);
   wire        ret_under   = (ret_top > high_r) | (ret_top < top_r);
   wire [2:0]  ctl_rl      = mem_rdata[slu_pkg::CTL_RL_LSB +: 3];
   wire [WORK_W-1:0] ctl_n = mem_rdata[slu_pkg::CTL_N_LSB +: WORK_W];
   wire        access      = (state_r inside {S_RD_HIGH, S_RD_LOW, S_RD_TOP, S_RD_CTL,
                                              S_XFER, S_WR_CTL, S_WR_TOP});

   // storage request fields for the current step
   logic [15:0] acc_addr;
   logic [15:0] acc_wdata;
   logic        acc_we;
   always_comb
   begin
      acc_addr  = slot_addr;
      acc_wdata = gpr_r[slot_reg];
      acc_we    = 1'b0;
      case (state_r)
         S_RD_HIGH: acc_addr = 16'(scb_r + slu_pkg::SCB_HIGH_OFS);
         S_RD_LOW:  acc_addr = 16'(scb_r + slu_pkg::SCB_LOW_OFS);
         S_RD_TOP:  acc_addr = 16'(scb_r + slu_pkg::SCB_TOP_OFS);
         S_RD_CTL:  acc_addr = top_r;
         S_XFER:    acc_we   = is_store;
         S_WR_CTL:
         begin
            acc_addr  = new_top_r;
            acc_wdata = ctl_word;
            acc_we    = 1'b1;
         end
         S_WR_TOP:
         begin
            acc_addr  = 16'(scb_r + slu_pkg::SCB_TOP_OFS);
            acc_wdata = new_top_r;
            acc_we    = 1'b1;
         end
         default: acc_addr = slot_addr;
      endcase
   end

   // =========================================================
   // storage port: hold request until ack
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         mem_req_r   <= 1'b0;
         mem_we_r    <= 1'b0;
         mem_addr_r  <= slu_pkg::WORD_RST;
         mem_wdata_r <= slu_pkg::WORD_RST;
      end
      else
      begin
         mem_req_r   <= access & ~mem_ack;
         mem_we_r    <= acc_we;
         mem_addr_r  <= acc_addr;
         mem_wdata_r <= acc_wdata;
      end
   end

   // =========================================================
   // sequencer
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state_r       <= S_IDLE;
         op_r          <= slu_pkg::SLU_OP_POP_WORD;
         reg_r         <= 3'h0;
         work_r        <= '0;
         scb_r         <= slu_pkg::WORD_RST;
         high_r        <= slu_pkg::WORD_RST;
         low_r         <= slu_pkg::WORD_RST;
         top_r         <= slu_pkg::WORD_RST;
         new_top_r     <= slu_pkg::WORD_RST;
         slot_r        <= 4'h0;
         done_r        <= 1'b0;
         stack_trap_r  <= 1'b0;
         stack_empty_r <= 1'b0;
         busy_r        <= 1'b0;
      end
      else
      begin
         done_r       <= 1'b0;
         stack_trap_r <= 1'b0;
         case (state_r)
            S_IDLE:
               if (cmd_start)
               begin
                  op_r    <= slu_pkg::slu_op_e'(cmd_op);
                  reg_r   <= cmd_reg;
                  work_r  <= cmd_work;
                  scb_r   <= cmd_scb_addr;
                  slot_r  <= 4'h0;
                  busy_r  <= 1'b1;
                  state_r <= S_RD_HIGH;
               end
            S_RD_HIGH:
               if (mem_ack)
               begin
                  high_r  <= mem_rdata;
                  state_r <= S_RD_LOW;
               end
            S_RD_LOW:
               if (mem_ack)
               begin
                  low_r   <= mem_rdata;
                  state_r <= S_RD_TOP;
               end
            S_RD_TOP:
               if (mem_ack)
               begin
                  top_r         <= mem_rdata;
                  stack_empty_r <= (mem_rdata == high_r);
                  state_r       <= S_CHECK;
               end
            S_CHECK:
            begin
               new_top_r <= is_store ? push_top : 16'(top_r + slu_pkg::WORD_BYTES);
               if (is_store ? overflow : underflow)
                  state_r <= S_FINISH;
               else if (is_lmb)
                  state_r <= S_RD_CTL;
               else
                  state_r <= S_XFER;
            end
            S_RD_CTL:
               if (mem_ack)
               begin
                  reg_r     <= ctl_rl;
                  work_r    <= ctl_n;
                  new_top_r <= top_r;
                  state_r   <= S_CHECK_RET;
               end
            S_CHECK_RET:
            begin
               new_top_r <= ret_top;
               state_r   <= ret_under ? S_FINISH : S_XFER;
            end
            S_XFER:
               if (mem_ack)
               begin
                  slot_r <= 4'(slot_r + 4'h1);
                  if (slot_last)
                     state_r <= is_stm ? S_WR_CTL : S_WR_TOP;
               end
            S_WR_CTL:
               if (mem_ack)
                  state_r <= S_SET_RL;
            S_SET_RL:
               state_r <= S_WR_TOP;
            S_WR_TOP:
               if (mem_ack)
               begin
                  top_r   <= new_top_r;
                  state_r <= S_FINISH;
               end
            S_FINISH:
            begin
               stack_trap_r  <= (top_r != new_top_r);
               stack_empty_r <= (top_r == high_r);
               done_r        <= 1'b1;
               busy_r        <= 1'b0;
               state_r       <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // =========================================================
   // general registers and instruction pointer
   wire ld_slot = (state_r == S_XFER) & mem_ack & ~is_store;
   wire ld_rl   = (state_r == S_SET_RL);
   wire ld_ip   = (state_r == S_WR_TOP) & mem_ack & is_lmb;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         for (int i = 0; i < slu_pkg::NUM_REGS; i++)
            gpr_r[i] <= slu_pkg::WORD_RST;
         instruction_pointer_r <= slu_pkg::WORD_RST;
         reg_rd_data_r         <= slu_pkg::WORD_RST;
      end
      else
      begin
         if (ld_slot)
            gpr_r[slot_reg] <= mem_rdata;
         else if (ld_rl)
            gpr_r[reg_r] <= work_ptr;
         else if (reg_wr_en && !busy_r)
            gpr_r[reg_wr_idx] <= reg_wr_data;
         if (ld_ip)
            instruction_pointer_r <= gpr_r[slu_pkg::LINK_REG];
         reg_rd_data_r <= gpr_r[reg_rd_idx];
      end
   end

   // =========================================================
   // assertions
   wire fail_path = (state_r == S_CHECK) & (is_store ? overflow : underflow);

   push_ovf_trap_a: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == S_CHECK) && is_store && overflow |-> ##2 stack_trap_r && done_r)
      else $error("overflow did not trap");
   pop_under_trap_a: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == S_CHECK) && !is_store && underflow |-> ##2 stack_trap_r)
      else $error("underflow did not trap");
   fail_no_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      fail_path |=> (state_r == S_FINISH) && !mem_req_r)
      else $error("failed op touched storage");
   top_kept_a: assert property (@(posedge clk_sys) disable iff (reset)
      fail_path |=> $stable(top_r))
      else $error("top pointer moved on failure");
   block_size_a: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == S_CHECK) && is_stm |->
      blk_bytes == 16'((16'(work_r) + 16'(reg_count(reg_r)) + 16'h0001) * 2))
      else $error("block size wrong");
   link_first_a: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == S_XFER) && is_stm && slot_r == 4'h0 && mem_req_r |->
      mem_we_r && mem_wdata_r == gpr_r[slu_pkg::LINK_REG])
      else $error("link register not stored first");
   rl_ptr_a: assert property (@(posedge clk_sys) disable iff (reset)
      ld_rl && work_r == '0 |=> gpr_r[reg_r] == link_slot)
      else $error("pointer not at link slot");
   ip_load_a: assert property (@(posedge clk_sys) disable iff (reset)
      ld_ip |=> instruction_pointer_r == $past(gpr_r[slu_pkg::LINK_REG]) ##1 done_r)
      else $error("return did not branch");
   top_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == S_WR_TOP) && mem_req_r |->
      mem_we_r && mem_addr_r == 16'(scb_r + slu_pkg::SCB_TOP_OFS) && mem_wdata_r == new_top_r)
      else $error("top pointer write wrong");

   stm_ok_c: cover property (@(posedge clk_sys) disable iff (reset) ld_rl);
   lmb_ok_c: cover property (@(posedge clk_sys) disable iff (reset) ld_ip);
   trap_c:   cover property (@(posedge clk_sys) disable iff (reset) stack_trap_r);
   pop_c:    cover property (@(posedge clk_sys) disable iff (reset)
      done_r && !stack_trap_r && $past(op_r == slu_pkg::SLU_OP_POP_WORD));
endmodule : slu_core
`default_nettype wire

/* File: bench/slu_mem_model.sv */
/*
 * slu_mem_model: word-wide main storage that answers each held request with a one-cycle ack.
 * Assumes the requester holds req, we, addr and wdata until the ack edge; lat sets the delay.
 */
`timescale 1ns/1ps
`default_nettype none
module slu_mem_model
(
   // clock
   input  wire logic        clk_sys,
   // request
   input  wire logic        mem_req_r,
   input  wire logic        mem_we_r,
   input  wire logic [15:0] mem_addr_r,
   input  wire logic [15:0] mem_wdata_r,
   input  wire logic [1:0]  lat,
   // answer
   output var  logic [15:0] mem_rdata,
   output var  logic        mem_ack
);
   // =========================================================
   // storage and answer timing
   logic [15:0] store [0:32767];
   logic [1:0]  wait_r;
   initial
   begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
      wait_r = 2'h0;
      for (int i = 0; i < 32768; i++)
         store[i] = 16'h0000;
   end
   // ack after lat extra cycles; read data flips outside the ack cycle
   always @(posedge clk_sys)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_r && !mem_ack)
      begin
         if (wait_r == lat)
         begin
            wait_r <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_we_r)
               store[mem_addr_r[15:1]] <= mem_wdata_r;
            else
               mem_rdata <= store[mem_addr_r[15:1]];
         end
         else
            wait_r <= wait_r + 2'h1;
      end
   end
endmodule : slu_mem_model
`default_nettype wire

/* File: bench/stack_linkage_unit_tb.sv */
/*
 * stack_linkage_unit_tb: drives slu_core and compares it with an integer stack model.
 * Assumes slu_mem_model as storage, control block at a fixed address, inputs at falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module stack_linkage_unit_tb;
   // =========================================================
   // signals and model state
   localparam logic [15:0] SCB = 16'h0100;
   logic        clk_sys, reset, cmd_start, reg_wr_en, busy_r, done_r, stack_trap_r;
   logic        stack_empty_r, mem_req_r, mem_we_r, mem_ack;
   logic [1:0]  cmd_op, lat;
   logic [2:0]  cmd_reg, reg_wr_idx, reg_rd_idx;
   logic [7:0]  cmd_work;
   logic [15:0] cmd_scb_addr, reg_wr_data, reg_rd_data_r, instruction_pointer_r;
   logic [15:0] mem_addr_r, mem_wdata_r, mem_rdata;
   int          n_mismatch, cmp_count, seed, cycles, high_m, low_m, top_m, ip_m;
   int          regs_m [8];
   int          frame_q [$];
   int          snap_q [$];
   // =========================================================
   // design and storage
   slu_core #(.WORK_W(8)) i_dut (.clk_sys, .reset, .cmd_start, .cmd_op, .cmd_reg, .cmd_work,
      .cmd_scb_addr, .reg_wr_en, .reg_wr_idx, .reg_wr_data, .reg_rd_idx, .reg_rd_data_r,
      .busy_r, .done_r, .stack_trap_r, .stack_empty_r, .instruction_pointer_r, .mem_req_r,
      .mem_we_r, .mem_addr_r, .mem_wdata_r, .mem_rdata, .mem_ack);
   slu_mem_model i_mem (.clk_sys, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r, .lat,
      .mem_rdata, .mem_ack);
   // =========================================================
   // clock and hang limit
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   // =========================================================
   // helpers
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // register write; enable stays up until the next command lowers it
   task automatic wr(int idx, int data);
      reg_wr_en = 1'b1;
      reg_wr_idx = 3'(idx);
      reg_wr_data = 16'(data);
      regs_m[idx] = data & 32'h0000_ffff;
      @(negedge clk_sys);
   endtask : wr
   task automatic set_stack(int hi, int lo, int tp);
      high_m = hi;
      low_m = lo;
      top_m = tp;
      i_mem.store[SCB[15:1]] = 16'(hi);
      i_mem.store[SCB[15:1] + 15'h0001] = 16'(lo);
      i_mem.store[SCB[15:1] + 15'h0002] = 16'(tp);
   endtask : set_stack
   // one command: model first, then run, then compare every visible result
   task automatic op(int kind, int r, int n);
      int   t, nreg, blk, k, f;
      int   exp_q [$];
      logic trap_m;
      trap_m = 1'b0;
      nreg = (r == 7) ? 1 : r + 2;
      if (kind == 0)
      begin
         trap_m = top_m >= high_m;
         if (!trap_m)
         begin
            regs_m[r] = i_mem.store[top_m[15:1]];
            top_m += 2;
         end
      end
      else if (kind == 1)
      begin
         t = top_m - 2;
         trap_m = t < low_m;
         if (!trap_m)
         begin
            exp_q = {t, regs_m[r]};
            top_m = t;
         end
      end
      else if (kind == 2)
      begin
         blk = n + nreg + 1;
         t = top_m - 2 * blk;
         trap_m = t < low_m || t < 0;
         if (!trap_m)
         begin
            exp_q = {t, r * 256 + n, t + 2 * n + 2, regs_m[7]};
            for (k = 0; k < nreg - 1; k++)
               exp_q = {exp_q, t + 2 * n + 4 + 2 * k, regs_m[k]};
            frame_q.push_back(r * 256 + n);
            for (k = 0; k < 8; k++)
               snap_q.push_back(regs_m[k]);
            regs_m[r] = t + 2;
            top_m = t;
         end
      end
      else
      begin
         trap_m = top_m >= high_m;
         if (!trap_m)
         begin
            f = frame_q[$];
            blk = f % 256 + ((f / 256 == 7) ? 1 : f / 256 + 2) + 1;
            trap_m = top_m + 2 * blk > high_m;
         end
         if (!trap_m)
         begin
            f = frame_q.pop_back() / 256;
            for (k = 7; k >= 0; k--)
            begin
               t = snap_q.pop_back();
               if (k == 7 || (f != 7 && k <= f))
                  regs_m[k] = t;
            end
            top_m += 2 * blk;
            ip_m = regs_m[7];
         end
      end
      reg_wr_en = 1'b0;
      cmd_op = 2'(kind);
      cmd_reg = 3'(r);
      cmd_work = 8'(n);
      lat = 2'($random(seed));
      cmd_start = 1'b1;
      @(negedge clk_sys);
      cmd_start = 1'b0;
      for (k = 0; k < 500 && done_r !== 1'b1; k++)
         @(negedge clk_sys);
      check("done", {15'h0000, done_r}, 16'h0001);
      check("trap", {15'h0000, stack_trap_r}, {15'h0000, trap_m});
      check("empty", {15'h0000, stack_empty_r}, {15'h0000, top_m == high_m});
      check("top", i_mem.store[SCB[15:1] + 15'h0002], 16'(top_m));
      check("ip", instruction_pointer_r, 16'(ip_m));
      while (exp_q.size() > 0)
      begin
         t = exp_q.pop_front();
         check("slot", i_mem.store[t[15:1]], 16'(exp_q.pop_front()));
      end
      for (k = 0; k < 8; k++)
      begin
         reg_rd_idx = 3'(k);
         @(negedge clk_sys);
         check("reg", reg_rd_data_r, 16'(regs_m[k]));
      end
   endtask : op
   // =========================================================
   // main sequence
   initial
   begin
      int k, j;
      seed = 30787;
      reset = 1'b1;
      cmd_start = 1'b0;
      cmd_op = 2'h0;
      cmd_reg = 3'h0;
      cmd_work = 8'h00;
      cmd_scb_addr = SCB;
      reg_wr_en = 1'b0;
      reg_wr_idx = 3'h0;
      reg_wr_data = 16'h0000;
      reg_rd_idx = 3'h0;
      lat = 2'h0;
      repeat (10) @(negedge clk_sys);
      reset = 1'b0;
      // pops, a push between them, then a pop from the empty stack
      set_stack(16'h0B08, 16'h0A00, 16'h0B00);
      for (k = 0; k < 4; k++)
         i_mem.store[15'h0580 + 15'(k)] = 16'($random(seed));
      op(0, 2, 0);
      op(0, 5, 0);
      op(1, 2, 0);
      op(0, 3, 0);
      op(0, 4, 0);
      op(0, 6, 0);
      op(0, 1, 0);
      // push at the low limit must trap
      set_stack(16'h0B08, 16'h0B06, 16'h0B06);
      op(1, 0, 0);
      // nested block pushes over every limit register, then unwind
      set_stack(16'h0B08, 16'h0800, 16'h0B08);
      for (k = 0; k < 8; k++)
      begin
         for (j = 0; j < 8; j++)
            wr(j, $random(seed));
         op(2, k, (k % 3 == 0) ? 0 : $random(seed) & 15);
      end
      for (k = 0; k < 9; k++)
         op(3, 0, 0);
      // block push overflow, then a return whose block runs past the high limit
      set_stack(16'h0B08, 16'h0AF0, 16'h0B08);
      op(2, 7, 20);
      op(2, 4, 3);
      set_stack(top_m + 4, 16'h0AF0, top_m);
      op(3, 0, 0);
      conclude();
   end
endmodule : stack_linkage_unit_tb
`default_nettype wire
